// *** rtl/adcsc_pkg.sv ***
// package of constants for the converter sequencer control block
package adcsc_pkg;
   // register byte addresses (offsets are multiples of four: index * 4)
   localparam logic [7:0] IDX_CONV_CTRL = 8'h1F;
   localparam logic [7:0] IDX_PORT_CFG = 8'h9F;
   localparam logic [7:0] IDX_RES_HIGH = 8'h1E;
   localparam logic [7:0] IDX_RES_LOW = 8'h9E;
   localparam logic [7:0] IDX_STATUS = 8'h20;
   localparam logic [9:0] ADDR_CONV_CTRL = {IDX_CONV_CTRL, 2'b00};
   localparam logic [9:0] ADDR_PORT_CFG = {IDX_PORT_CFG, 2'b00};
   localparam logic [9:0] ADDR_RES_HIGH = {IDX_RES_HIGH, 2'b00};
   localparam logic [9:0] ADDR_RES_LOW = {IDX_RES_LOW, 2'b00};
   localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
   // conversion control fields
   localparam int CC_CLK_LSB = 6;
   localparam int CC_CHAN_LSB = 3;
   localparam int CC_GO_BIT = 2;
   localparam int CC_ON_BIT = 0;
   // port config fields
   localparam int PC_FMT_BIT = 7;
   localparam int PC_HALVE_BIT = 6;
   localparam logic [7:0] CONV_CTRL_RST = 8'h00;
   localparam logic [7:0] PORT_CFG_RST = 8'h00;
   localparam logic [7:0] CONV_CTRL_WMASK = 8'hFD;
   localparam logic [7:0] PORT_CFG_WMASK = 8'hCF;
   // timing in bit periods
   localparam int BITS_PER_CONV = 10;
   localparam int GAP_PERIODS = 2;
   localparam int STEP_PERIODS = 9;
   localparam int CONV_PERIODS = BITS_PER_CONV + 2;
   // rc clock period and bus clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int RC_PERIOD_NS = 4000;
   localparam int RC_HALF_CYC = RC_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam logic [1:0] AXI_OKAY = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

// *** rtl/adcsc_tad_gen.sv ***
// bit period tick generator: divided system clock or internal rc clock
`timescale 1ns/10ps
module adcsc_tad_gen #(
   parameter int RC_HALF = adcsc_pkg::RC_HALF_CYC
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_run,
   input wire logic [1:0] i_sel,
   input wire logic i_halve,
   output logic o_tick
);
   logic [6:0] div_q;
   logic [6:0] div_d;
   logic [6:0] limit;
   logic [15:0] rc_cnt_q;
   logic rc_clk_q;
   logic rc_s1_q;
   logic rc_s2_q;
   logic rc_s3_q;
   logic use_rc;
   logic sys_tick;
   logic rc_tick;
   logic [6:0] base;

   assign base = (i_sel == 2'b00) ? 7'h02 :
                 (i_sel == 2'b01) ? 7'h08 : 7'h20;
   // halve bit doubles system dividers only
   assign limit = i_halve ? {base[5:0], 1'b0} : base;
   assign use_rc = (i_sel == 2'b11);
   assign sys_tick = (div_q == limit - 7'h01);
   assign div_d = (sys_tick || !i_run) ? 7'h00 : div_q + 7'h01;
   // rc edge passes two flops before use
   assign rc_tick = rc_s2_q & ~rc_s3_q;

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         div_q <= 7'h00;
         rc_cnt_q <= 16'h0000;
         rc_clk_q <= 1'b0;
         rc_s1_q <= 1'b0;
         rc_s2_q <= 1'b0;
         rc_s3_q <= 1'b0;
         o_tick <= 1'b0;
      end
      else
      begin
         div_q <= div_d;
         // stands in for the free-running rc oscillator
         if (rc_cnt_q == 16'(RC_HALF - 1))
         begin
            rc_cnt_q <= 16'h0000;
            rc_clk_q <= ~rc_clk_q;
         end
         else
         begin
            rc_cnt_q <= rc_cnt_q + 16'h0001;
         end
         rc_s1_q <= rc_clk_q;
         rc_s2_q <= rc_s1_q;
         rc_s3_q <= rc_s2_q;
         o_tick <= i_run & (use_rc ? rc_tick : sys_tick);
      end
   end
endmodule

// *** rtl/adcsc_top.sv ***
// converter sequencer control with axi4-lite register slave
`timescale 1ns/10ps
// Notes on behaviour
// - clock select 00/01/10 gives sysclk/2, /8, /32; 11 rc clock.
// - halve bit doubles system dividers to /4, /16, /64; rc unchanged.
// - channel code 000..100 selects input zero to four.
// - go write with converter on starts during acquisition; go reads one while busy.
// - hardware clears go at completion without a software write.
// - completion loads result, clears go and sets done flag together.
// - converter-on bit enables; off shuts converter fully down.
// - unimplemented control bits ignore writes and read zero.
// - format one right justifies, zero left justifies, spare bits zero.
// - port config code sets each pin analog or digital.
// - port config code also selects the reference sources.
// - each conversion yields a ten bit value of the input.
// - two bit periods pass after completion before the next acquisition, one to two after an abort.
// - holding capacitor stays disconnected during the two-period gap.
// - holding capacitor is never discharged between conversions.
// - sequencer spends twelve bit periods per ten-bit conversion.
// - clearing go mid-conversion aborts, result kept, gap then acquire.
// - compare trigger sets go only while the converter is on.
module adcsc_top #(
   parameter int RC_HALF = adcsc_pkg::RC_HALF_CYC
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [11:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [11:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic i_trigger,
   input wire logic i_cmp_bit,
   output logic o_sar_bit,
   output logic [4:0] o_chan_sel,
   output logic o_sample,
   output logic o_analog_pwr,
   output logic [4:0] o_pin_analog,
   output logic o_vref_pos_pin,
   output logic o_vref_neg_pin,
   output logic o_done_pulse
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ACQ = 4'b0010,
      ST_CONV = 4'b0100,
      ST_GAP = 4'b1000
   } adcsc_state_t;

   adcsc_state_t st_q, st_d;
   logic [7:0] cc_q;
   logic [7:0] pc_q;
   logic [9:0] res_q;
   logic [9:0] sar_q;
   logic [3:0] bit_q;
   logic [1:0] gap_q;
   logic done_flag_q;
   logic aw_q, w_q;
   logic [9:0] awa_q;
   logic [7:0] wd_q;
   logic tick;
   logic go, on;
   logic wr_fire, rd_fire;
   logic wr_cc, wr_pc, wr_st;
   logic sw_go, sw_stop, hw_start, finish, abort;
   logic [9:0] rd_a;
   logic [7:0] rd_byte;
   logic rd_ok, wr_ok;
   logic [7:0] res_hi, res_lo;
   logic [3:0] pcfg;

   // ---------------------------------------------------------------
   // bit period timing
   // ---------------------------------------------------------------
   adcsc_tad_gen #(.RC_HALF(RC_HALF)) u_tad (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_run(st_q != ST_IDLE),
      .i_sel(cc_q[adcsc_pkg::CC_CLK_LSB +: 2]),
      .i_halve(pc_q[adcsc_pkg::PC_HALVE_BIT]),
      .o_tick(tick)
   );

   // ---------------------------------------------------------------
   // register bus decode
   // ---------------------------------------------------------------
   assign on = cc_q[adcsc_pkg::CC_ON_BIT];
   assign go = cc_q[adcsc_pkg::CC_GO_BIT];
   assign pcfg = pc_q[3:0];
   assign wr_fire = aw_q & w_q & ~o_s_axi_bvalid;
   assign wr_cc = wr_fire && awa_q == adcsc_pkg::ADDR_CONV_CTRL;
   assign wr_pc = wr_fire && awa_q == adcsc_pkg::ADDR_PORT_CFG;
   assign wr_st = wr_fire && awa_q == adcsc_pkg::ADDR_STATUS;
   assign wr_ok = wr_cc | wr_pc | wr_st;
   assign rd_fire = i_s_axi_arvalid & o_s_axi_arready;
   assign rd_a = i_s_axi_araddr[9:0];
   assign rd_ok = (i_s_axi_araddr[11:10] == 2'b00) &&
      (rd_a == adcsc_pkg::ADDR_CONV_CTRL ||
       rd_a == adcsc_pkg::ADDR_PORT_CFG ||
       rd_a == adcsc_pkg::ADDR_RES_HIGH ||
       rd_a == adcsc_pkg::ADDR_RES_LOW ||
       rd_a == adcsc_pkg::ADDR_STATUS);
   assign res_hi = pc_q[adcsc_pkg::PC_FMT_BIT] ? {6'h00, res_q[9:8]}
                                               : res_q[9:2];
   assign res_lo = pc_q[adcsc_pkg::PC_FMT_BIT] ? res_q[7:0]
                                               : {res_q[1:0], 6'h00};
   assign rd_byte =
      (rd_a == adcsc_pkg::ADDR_CONV_CTRL) ? cc_q :
      (rd_a == adcsc_pkg::ADDR_PORT_CFG) ? pc_q :
      (rd_a == adcsc_pkg::ADDR_RES_HIGH) ? res_hi :
      (rd_a == adcsc_pkg::ADDR_RES_LOW) ? res_lo :
      (rd_a == adcsc_pkg::ADDR_STATUS) ? {7'h00, done_flag_q} : 8'h00;

   // software go start; refused when off
   assign sw_go = wr_cc & wd_q[adcsc_pkg::CC_GO_BIT] &
                  wd_q[adcsc_pkg::CC_ON_BIT] & ~go;
   assign sw_stop = wr_cc & ~wd_q[adcsc_pkg::CC_GO_BIT];
   assign hw_start = (sw_go | (i_trigger & on & ~wr_cc)) & st_q == ST_ACQ;
   // abort wins over a finish in the same cycle, result left untouched
   assign finish = st_q == ST_CONV && tick && bit_q == 4'h0 && !abort;
   // abort on go clear or converter off
   assign abort = st_q == ST_CONV && (sw_stop || (wr_cc &&
                  !wd_q[adcsc_pkg::CC_ON_BIT]));

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         ST_IDLE:
            st_d = on ? ST_ACQ : ST_IDLE;
         ST_ACQ:
            st_d = !on ? ST_IDLE : hw_start ? ST_CONV : ST_ACQ;
         ST_CONV:
            st_d = (finish || abort) ? ST_GAP : ST_CONV;
         ST_GAP:
            st_d = (tick && gap_q == 2'(adcsc_pkg::GAP_PERIODS - 1)) ?
                   (on ? ST_ACQ : ST_IDLE) : ST_GAP;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         st_q <= ST_IDLE;
         bit_q <= 4'h0;
         gap_q <= 2'b00;
         sar_q <= 10'h000;
      end
      else
      begin
         st_q <= st_d;
         if (st_q != ST_GAP)
            gap_q <= 2'b00;
         else if (tick)
            gap_q <= gap_q + 2'b01;
         if (hw_start)
         begin
            bit_q <= 4'(adcsc_pkg::CONV_PERIODS - 1);
            sar_q <= 10'h000;
         end
         else if (st_q == ST_CONV && tick && bit_q != 4'h0)
         begin
            bit_q <= bit_q - 4'h1;
            // one result bit per bit period, msb first
            if (bit_q <= 4'(adcsc_pkg::BITS_PER_CONV))
               sar_q[bit_q - 4'h1] <= i_cmp_bit;
         end
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cc_q <= adcsc_pkg::CONV_CTRL_RST;
         pc_q <= adcsc_pkg::PORT_CFG_RST;
         res_q <= 10'h000;
         done_flag_q <= 1'b0;
      end
      else
      begin
         // masked writes keep unimplemented bits zero
         if (wr_cc)
         begin
            cc_q <= (wd_q & adcsc_pkg::CONV_CTRL_WMASK) &
                    ~(8'h01 << adcsc_pkg::CC_GO_BIT);
            // go only reads one once a conversion has really started
            cc_q[adcsc_pkg::CC_GO_BIT] <= hw_start |
               (go & wd_q[adcsc_pkg::CC_GO_BIT] &
                wd_q[adcsc_pkg::CC_ON_BIT] & ~finish);
         end
         else if (hw_start)
            cc_q[adcsc_pkg::CC_GO_BIT] <= 1'b1;
         else if (finish || !on)
            cc_q[adcsc_pkg::CC_GO_BIT] <= 1'b0;
         if (wr_pc)
            pc_q <= wd_q & adcsc_pkg::PORT_CFG_WMASK;
         // result, go clear and flag together
         if (finish)
            res_q <= sar_q;
         // set wins over software clear
         if (finish)
            done_flag_q <= 1'b1;
         else if (wr_st && wd_q[0])
            done_flag_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite handshake
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 10'h000;
         wd_q <= 8'h00;
         o_s_axi_awready <= 1'b0;
         o_s_axi_wready <= 1'b0;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= adcsc_pkg::AXI_OKAY;
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= 32'h0000_0000;
         o_s_axi_rresp <= adcsc_pkg::AXI_OKAY;
      end
      else
      begin
         o_s_axi_awready <= ~aw_q & ~o_s_axi_awready & i_s_axi_awvalid;
         o_s_axi_wready <= ~w_q & ~o_s_axi_wready & i_s_axi_wvalid;
         if (o_s_axi_awready)
         begin
            aw_q <= 1'b1;
            awa_q <= (i_s_axi_awaddr[11:10] == 2'b00) ?
                     i_s_axi_awaddr[9:0] : 10'h3FF;
         end
         if (o_s_axi_wready)
         begin
            w_q <= 1'b1;
            wd_q <= i_s_axi_wstrb[0] ? i_s_axi_wdata[7:0] :
                    8'h00;
         end
         if (wr_fire)
         begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= wr_ok ? adcsc_pkg::AXI_OKAY :
                             adcsc_pkg::AXI_SLVERR;
         end
         else if (i_s_axi_bready)
            o_s_axi_bvalid <= 1'b0;
         o_s_axi_arready <= ~o_s_axi_arready & ~o_s_axi_rvalid &
                            i_s_axi_arvalid;
         if (rd_fire)
         begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata <= {24'h00_0000, rd_byte};
            o_s_axi_rresp <= rd_ok ? adcsc_pkg::AXI_OKAY :
                             adcsc_pkg::AXI_SLVERR;
         end
         else if (i_s_axi_rready)
            o_s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // analog front end controls
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_chan_sel <= 5'h00;
         o_sample <= 1'b0;
         o_analog_pwr <= 1'b0;
         o_pin_analog <= 5'h1F;
         o_vref_pos_pin <= 1'b0;
         o_vref_neg_pin <= 1'b0;
         o_done_pulse <= 1'b0;
         o_sar_bit <= 1'b0;
      end
      else
      begin
         // one-hot channel route, codes above 100 select none
         o_chan_sel <= (cc_q[5:3] <= 3'h4) ?
                       5'(5'h01 << cc_q[5:3]) : 5'h00;
         // switch open in gap; no discharge path exists
         o_sample <= (st_q == ST_ACQ) & on;
         o_analog_pwr <= on;
         o_pin_analog <= pin_map(pcfg);
         o_vref_pos_pin <= (pcfg[0] & ~pcfg[3] & (pcfg[2:1] != 2'b11)) |
                           (pcfg[3] & (pcfg != 4'h9) & (pcfg != 4'hE));
         o_vref_neg_pin <= pcfg[3] & (pcfg[2:0] == 3'h0 |
                           pcfg[1:0] == 2'b11 | pcfg[2] & ~pcfg[1]);
         o_done_pulse <= finish;
         o_sar_bit <= st_q == ST_CONV;
      end
   end

   function automatic logic [4:0] pin_map(input logic [3:0] c);
      unique case (c)
         4'h4, 4'h5, 4'hD: pin_map = 5'h0B;
         4'h6, 4'h7: pin_map = 5'h00;
         4'hE, 4'hF: pin_map = 5'h01;
         default: pin_map = 5'h1F;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);

   a_done_sets_flag: assert property (finish |=> done_flag_q)
      else $error("done flag not set at completion");
   a_done_clears_go: assert property (finish && !wr_cc |=> !go)
      else $error("go not cleared at completion");
   a_off_no_go: assert property (!on |=> !go || $past(wr_cc))
      else $error("go set while converter off");
   a_gap_no_sample: assert property (st_q == ST_GAP |=> !o_sample)
      else $error("sampling during gap");
   a_abort_keeps: assert property (abort |=> $stable(res_q))
      else $error("result changed on abort");
   a_unimpl_zero: assert property (!cc_q[1] && pc_q[5:4] == 2'b00)
      else $error("unimplemented bit set");
   a_pwr_follows: assert property (##1 o_analog_pwr == $past(on))
      else $error("power not tracking on bit");
   a_gap_before_acq: assert property (
      st_q == ST_CONV && st_d == ST_GAP |=> st_q == ST_GAP [*2])
      else $error("gap too short");
   a_trig_off: assert property (
      i_trigger && !on && st_q != ST_CONV |=> st_q != ST_CONV)
      else $error("trigger started while off");
   a_rjust_zero: assert property (
      pc_q[adcsc_pkg::PC_FMT_BIT] |-> res_hi[7:2] == 6'h00)
      else $error("right justify spare bits nonzero");

   c_conv_done: cover property (finish);
   c_abort: cover property (abort);
   c_trigger: cover property (hw_start && !wr_cc);
endmodule

// *** tb/adcsc_front_model.sv ***
// analog front end model: channel levels, holding capacitor, comparator
`timescale 1ns/10ps
module adcsc_front_model #(
   parameter logic [4:0] LEVELS = 5'h15
) (
   input wire logic i_clk,
   input wire logic [4:0] i_chan_sel,
   input wire logic i_sample,
   input wire logic i_sar_bit,
   output logic o_cmp_bit
);
   // ----------------------------------------
   // holding capacitor and comparator
   // ----------------------------------------
   // channel pins are inputs: only their levels are read
   logic hold_q = 1'b0;
   logic idle_q = 1'b0;
   always_ff @(posedge i_clk)
   begin
      if (i_sample) hold_q <= |(i_chan_sel & LEVELS);
      idle_q <= ~idle_q;
   end
   // decision follows held charge; toggles outside conversion
   assign o_cmp_bit = i_sar_bit ? hold_q : idle_q;
endmodule

// *** tb/test_adcsc_top.sv ***
// self-checking bench for the converter sequencer control block
`timescale 1ns/10ps
module test_adcsc_top;
   // ----------------------------------------
   // signals and design
   // ----------------------------------------
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic [11:0] aw_a = 12'h000;
   logic [11:0] ar_a = 12'h000;
   logic [31:0] w_d = 32'h0;
   logic aw_v = 1'b0;
   logic w_v = 1'b0;
   logic ar_v = 1'b0;
   logic trig = 1'b0;
   logic cmp, aw_r, w_r, b_v, ar_r, r_v, sar, samp, pwr, vp, vn, done;
   logic [1:0] b_resp, r_resp, rsp;
   logic [31:0] r_d, rdv;
   logic [4:0] chan, pin;
   int cyc = 0;
   int err_total = 0;
   int num_checks = 0;
   localparam logic [4:0] CH_MASK [16] = '{5'h1F, 5'h17, 5'h1F, 5'h17,
      5'h0B, 5'h03, 5'h00, 5'h00, 5'h13, 5'h1F, 5'h17, 5'h13, 5'h13,
      5'h03, 5'h01, 5'h01};
   localparam logic [15:0] POS_REF = 16'hBD2A;
   localparam logic [15:0] NEG_REF = 16'hB900;

   initial forever #5 i_clk = ~i_clk;
   always @(posedge i_clk) cyc <= cyc + 1;

   adcsc_top #(.RC_HALF(2)) adcsc_top_i (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_s_axi_awaddr(aw_a),
      .i_s_axi_awvalid(aw_v), .o_s_axi_awready(aw_r), .i_s_axi_wdata(w_d),
      .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(w_v), .o_s_axi_wready(w_r),
      .o_s_axi_bresp(b_resp), .o_s_axi_bvalid(b_v), .i_s_axi_bready(1'b1),
      .i_s_axi_araddr(ar_a), .i_s_axi_arvalid(ar_v),
      .o_s_axi_arready(ar_r), .o_s_axi_rdata(r_d), .o_s_axi_rresp(r_resp),
      .o_s_axi_rvalid(r_v), .i_s_axi_rready(1'b1), .i_trigger(trig),
      .i_cmp_bit(cmp), .o_sar_bit(sar), .o_chan_sel(chan),
      .o_sample(samp), .o_analog_pwr(pwr), .o_pin_analog(pin),
      .o_vref_pos_pin(vp), .o_vref_neg_pin(vn), .o_done_pulse(done));

   adcsc_front_model adcsc_front_model_i (.i_clk(i_clk),
      .i_chan_sel(chan), .i_sample(samp), .i_sar_bit(sar),
      .o_cmp_bit(cmp));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // bready is tied high, so the response is taken where bvalid is seen
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      aw_a <= {2'b00, a};
      w_d <= {24'h000000, d};
      aw_v <= 1'b1;
      w_v <= 1'b1;
      for (int k = 0; k < 64; k++)
      begin
         @(posedge i_clk);
         if (aw_r === 1'b1) aw_v <= 1'b0;
         if (w_r === 1'b1) w_v <= 1'b0;
         if (b_v === 1'b1) break;
      end
      rsp = b_resp;
   endtask

   task automatic rd(input logic [9:0] a);
      ar_a <= {2'b00, a};
      ar_v <= 1'b1;
      for (int k = 0; k < 64; k++)
      begin
         @(posedge i_clk);
         if (ar_r === 1'b1) ar_v <= 1'b0;
         if (r_v === 1'b1) break;
      end
      rdv = r_d;
      rsp = r_resp;
   endtask

   task automatic wait_done(output int t);
      for (t = 0; t < 3000; t++)
      begin
         @(posedge i_clk);
         if (done === 1'b1) break;
      end
   endtask

   // the switch must stay open for the whole conversion
   always @(posedge i_clk)
      if (sar === 1'b1) chk("sample_in_conv", 32'(samp), 32'h0);

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      rd(adcsc_pkg::ADDR_CONV_CTRL);
      chk("conv_rst", rdv, 32'h0);
      rd(adcsc_pkg::ADDR_PORT_CFG);
      chk("port_rst", rdv, 32'h0);
      chk("pin_rst", 32'(pin), 32'h1F);
      rd(10'h004);
      chk("unmapped_rd", {rdv[29:0], rsp}, 32'(adcsc_pkg::AXI_SLVERR));
      wr(10'h004, 8'hFF);
      chk("unmapped_wr", 32'(rsp), 32'(adcsc_pkg::AXI_SLVERR));
   endtask

   task automatic t_bits;
      wr(adcsc_pkg::ADDR_CONV_CTRL, 8'hFE);
      rd(adcsc_pkg::ADDR_CONV_CTRL);
      chk("conv_spare_go", rdv, 32'hF8);
      chk("sar_off", 32'(sar), 32'h0);
      wr(adcsc_pkg::ADDR_PORT_CFG, 8'hFF);
      rd(adcsc_pkg::ADDR_PORT_CFG);
      chk("port_spare", rdv, 32'hCF);
      wr(adcsc_pkg::ADDR_CONV_CTRL, 8'h01);
      ticks(2);
      chk("pwr_on", 32'(pwr), 32'h1);
      wr(adcsc_pkg::ADDR_CONV_CTRL, 8'h00);
      ticks(2);
      chk("pwr_off", 32'(pwr), 32'h0);
      chk("sample_off", 32'(samp), 32'h0);
   endtask

   // reference pins are masked so either reading of them as analog fits
   task automatic t_pcfg;
      for (int c = 0; c < 16; c++)
      begin
         wr(adcsc_pkg::ADDR_PORT_CFG, 8'(c));
         ticks(2);
         chk("pin_analog", 32'(pin & ~{1'b0, POS_REF[c], NEG_REF[c],
            2'b00}), 32'(CH_MASK[c]));
         chk("vref_pos", 32'(vp), 32'(POS_REF[c]));
         chk("vref_neg", 32'(vn), 32'(NEG_REF[c]));
      end
   endtask

   task automatic t_chan;
      for (int c = 0; c < 8; c++)
      begin
         wr(adcsc_pkg::ADDR_CONV_CTRL, {2'b00, 3'(c), 3'b001});
         ticks(2);
         chk("chan_sel", 32'(chan), (c < 5) ? 32'(5'h01 << c) : 32'h0);
      end
   endtask

   task automatic t_conv(input logic [1:0] sel, input logic halve);
      int n, t, t0;
      logic lvl;
      n = (sel == 2'b11) ? 4 : (2 << (2 * sel)) << halve;
      lvl = ~sel[0];
      wr(adcsc_pkg::ADDR_PORT_CFG, {halve, halve, 6'h00});
      wr(adcsc_pkg::ADDR_CONV_CTRL, {sel, 1'b0, sel, 3'b001});
      wr(adcsc_pkg::ADDR_STATUS, 8'h01);
      ticks(40);
      wr(adcsc_pkg::ADDR_CONV_CTRL, {sel, 1'b0, sel, 3'b101});
      t0 = cyc;
      rd(adcsc_pkg::ADDR_CONV_CTRL);
      chk("go_busy", rdv, 32'({sel, 1'b0, sel, 3'b101}));
      wait_done(t);
      t = cyc - t0;
      chk("conv_time", 32'(t >= 11 * n - 2 && t <= 12 * n + 6), 32'h1);
      t0 = cyc;
      for (int k = 0; k < 2000 && samp !== 1'b1; k++) @(posedge i_clk);
      chk("gap", 32'(cyc - t0 >= 2 * n - 1 && cyc - t0 <= 2 * n + 3),
         32'h1);
      rd(adcsc_pkg::ADDR_RES_HIGH);
      chk("res_high", rdv, lvl ? (halve ? 32'h03 : 32'hFF) : 32'h0);
      rd(adcsc_pkg::ADDR_RES_LOW);
      chk("res_low", rdv, lvl ? (halve ? 32'hFF : 32'hC0) : 32'h0);
      rd(adcsc_pkg::ADDR_STATUS);
      chk("done_flag", rdv, 32'h1);
      rd(adcsc_pkg::ADDR_CONV_CTRL);
      chk("go_cleared", rdv, 32'({sel, 1'b0, sel, 3'b001}));
   endtask

   // the previous result is all zeros; channel 0 would give ones
   task automatic t_abort;
      int dn;
      dn = 0;
      wr(adcsc_pkg::ADDR_PORT_CFG, 8'h80);
      wr(adcsc_pkg::ADDR_STATUS, 8'h01);
      wr(adcsc_pkg::ADDR_CONV_CTRL, 8'h81);
      ticks(40);
      wr(adcsc_pkg::ADDR_CONV_CTRL, 8'h85);
      ticks(20);
      wr(adcsc_pkg::ADDR_CONV_CTRL, 8'h81);
      rd(adcsc_pkg::ADDR_CONV_CTRL);
      chk("abort_go", rdv, 32'h81);
      for (int k = 0; k < 400; k++)
      begin
         @(posedge i_clk);
         if (done === 1'b1) dn++;
      end
      chk("abort_done", 32'(dn), 32'h0);
      chk("abort_reacq", 32'(samp), 32'h1);
      rd(adcsc_pkg::ADDR_RES_LOW);
      chk("abort_res", rdv, 32'h0);
      rd(adcsc_pkg::ADDR_STATUS);
      chk("abort_flag", rdv, 32'h0);
   endtask

   task automatic t_trig;
      int t;
      wr(adcsc_pkg::ADDR_CONV_CTRL, 8'h00);
      trig <= 1'b1;
      @(posedge i_clk);
      trig <= 1'b0;
      ticks(4);
      rd(adcsc_pkg::ADDR_CONV_CTRL);
      chk("trig_off", rdv, 32'h0);
      wr(adcsc_pkg::ADDR_CONV_CTRL, 8'h01);
      ticks(40);
      trig <= 1'b1;
      @(posedge i_clk);
      trig <= 1'b0;
      ticks(3);
      rd(adcsc_pkg::ADDR_CONV_CTRL);
      chk("trig_on", rdv, 32'h05);
      wait_done(t);
      chk("trig_done", 32'(t < 3000), 32'h1);
   endtask

   initial
   begin
      ticks(12);
      i_arst_n <= 1'b1;
      @(posedge i_clk);
      t_reset;
      t_bits;
      t_pcfg;
      t_chan;
      // every clock source, rc as the sleep choice
      for (int s = 0; s < 8; s++) t_conv(2'(s >> 1), 1'(s));
      t_abort;
      t_trig;
      close_out;
   end

   // whole run is a few thousand cycles; this is far beyond it
   initial
   begin
      #1000000;
      err_total++;
      close_out;
   end
endmodule
